// File: logic/cfw_top.v
// clock-fail detector, 8-bit watchdog and low-power sequencer
// assumes an axi4-lite master on aclk and a cpu that pulses cpu_idle_exec
//
// Contract
// - keep clocking cpu from limp clock on loss
// - limp fallback only after clock seen once
// - pll-off bit blocks the limp fallback
// - watchdog counter frozen while in limp
// - clock loss resets device, sets sticky flag
// - counter max drives reset low 512 osc
// - key 0x55 then 0xAA clears the counter
// - disabled watchdog never pulses reset
// - standby keeps watchdog, its irq wakes
// - idle: watchdog irq reaches cpu expander
// - halt stops oscillator, watchdog inactive
// - mode field 00 idle 01 standby 1x halt
// - idle exits: reset, wdog, irq, nmi
// - standby exits: reset, wdog, nmi, debug, gpio
// - only selected gpio lines may wake
// - standby gpio qualified for programmed osc count
// - halt exits: reset, gpio, nmi, debug only
// - low-power never disturbs output pin states
// - debug port alive in standby and halt
`include "cfw_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module cfw_top (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        osc_clock_ok,
   input  wire        ext_reset_n,
   input  wire        ext_nmi_n,
   input  wire        dbg_wake_req,
   input  wire [31:0] gpio_in,
   input  wire        cpu_idle_exec,
   input  wire        cpu_irq_pending,
   output reg         limp_clock_sel,
   output reg         device_reset_n,
   output reg         missing_clock_flag,
   output reg         wdog_reset_out_n,
   output reg         wdog_wake_irq,
   output reg  [1:0]  lp_state,
   output reg         cpu_clock_in_en,
   output reg         system_clock_out_en,
   output reg         osc_clock_en,
   output reg         lp_wake,
   output reg         pin_hold,
   output reg         jtag_alive
);

   // ************************************************************
   // state codes
   // ************************************************************
   localparam [1:0] ST_RUN     = 2'h0;
   localparam [1:0] ST_IDLE    = 2'h1;
   localparam [1:0] ST_STANDBY = 2'h2;
   localparam [1:0] ST_HALT    = 2'h3;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   wire [35:0] in_raw;
   reg  [35:0] sync1;
   reg  [35:0] sync2;
   reg  [35:0] sync3;
   reg  [35:0] in_filt;

   assign in_raw = {osc_clock_ok, dbg_wake_req, ext_nmi_n, ext_reset_n,
                    gpio_in};

   // three stages, a change counts once stages two and three agree
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1   <= {4'hB, 32'hFFFF_FFFF};
         sync2   <= {4'hB, 32'hFFFF_FFFF};
         sync3   <= {4'hB, 32'hFFFF_FFFF};
         in_filt <= {4'hB, 32'hFFFF_FFFF};
      end else begin
         sync1   <= in_raw;
         sync2   <= sync1;
         sync3   <= sync2;
         in_filt <= (sync2 & sync3) | (in_filt & (sync2 | sync3));
      end
   end

   wire        osc_ok_f  = in_filt[35];
   wire        dbg_f     = in_filt[34];
   wire        nmi_n_f   = in_filt[33];
   wire        xrst_n_f  = in_filt[32];
   wire [31:0] gpio_f    = in_filt[31:0];

   // ************************************************************
   // registers and bus state
   // ************************************************************
   reg  [2:0]  ctrl;
   reg  [7:0]  lowpower_ctrl0;
   reg  [31:0] gpio_wake_select;
   reg  [11:0] wr_addr;
   reg  [31:0] wr_data;
   reg  [3:0]  wr_strb;
   reg         key_armed;
   reg  [7:0]  wd_count;
   reg  [9:0]  wd_rst_cnt;
   reg  [3:0]  osc_div;
   reg         osc_tick;
   reg         clk_seen;
   reg         clk_lost;
   reg  [4:0]  dev_rst_cnt;
   reg  [5:0]  qual_cnt;
   reg  [31:0] wake_prev;
   reg         wd_irq_evt;

   wire [1:0]  lowpower_mode_sel = lowpower_ctrl0[1:0];
   wire [5:0]  qual_limit        = lowpower_ctrl0[7:2];
   wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                        {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire        wr_do = s_axi_awready & s_axi_awvalid;
   wire        wr_ctrl = wr_do && (wr_addr == `CFW_OFS_CTRL);
   wire        wr_lp   = wr_do && (wr_addr == `CFW_OFS_LPCTRL0);
   wire        wr_sel  = wr_do && (wr_addr == `CFW_OFS_WAKESEL);
   wire        wr_key  = wr_do && (wr_addr == `CFW_OFS_WDKEY) &&
                         wr_strb[0];
   wire        wr_st   = wr_do && (wr_addr == `CFW_OFS_STATUS);
   wire        wr_hit  = (wr_addr == `CFW_OFS_CTRL) ||
                         (wr_addr == `CFW_OFS_LPCTRL0) ||
                         (wr_addr == `CFW_OFS_WAKESEL) ||
                         (wr_addr == `CFW_OFS_WDKEY) ||
                         (wr_addr == `CFW_OFS_STATUS);

   // ************************************************************
   // axi4-lite write channel
   // ************************************************************
   // address and data taken together, response after both
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         wr_addr       <= 12'h000;
         wr_data       <= 32'h0000_0000;
         wr_strb       <= 4'h0;
      end else if (wr_do) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b1;
         s_axi_bresp   <= wr_hit ? 2'h0 : 2'h2; // slverr if unmapped
      end else if (s_axi_bvalid) begin
         if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         wr_addr       <= {s_axi_awaddr[11:2], 2'h0};
         wr_data       <= s_axi_wdata;
         wr_strb       <= s_axi_wstrb;
      end
   end

   // control registers with byte-lane merge
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl             <= `CFW_CTRL_RST;
         lowpower_ctrl0   <= `CFW_LPCTRL0_RST;
         gpio_wake_select <= `CFW_WAKESEL_RST;
      end else begin
         if (wr_ctrl && wr_strb[0]) begin
            ctrl <= wr_data[2:0];
         end
         if (wr_lp && wr_strb[0]) begin
            lowpower_ctrl0 <= wr_data[7:0];
         end
         if (wr_sel) begin
            gpio_wake_select <= (gpio_wake_select & ~wmask) |
                                (wr_data & wmask);
         end
      end
   end

   // ************************************************************
   // axi4-lite read channel
   // ************************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else if (s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid) begin
         s_axi_arready <= 1'b1;
         s_axi_rresp   <= 2'h0;
         s_axi_rdata   <= 32'h0000_0000;
         if (s_axi_araddr[11:2] == `CFW_OFS_CTRL >> 2) begin
            s_axi_rdata <= {29'h0, ctrl};
         end else if (s_axi_araddr[11:2] == `CFW_OFS_LPCTRL0 >> 2) begin
            s_axi_rdata <= {24'h0, lowpower_ctrl0};
         end else if (s_axi_araddr[11:2] == `CFW_OFS_WAKESEL >> 2) begin
            s_axi_rdata <= gpio_wake_select;
         end else if (s_axi_araddr[11:2] == `CFW_OFS_WDKEY >> 2) begin
            s_axi_rdata <= 32'h0000_0000;
         end else if (s_axi_araddr[11:2] == `CFW_OFS_STATUS >> 2) begin
            s_axi_rdata <= {15'h0, ~wdog_reset_out_n, wd_count,
                            4'h0, lp_state, limp_clock_sel,
                            missing_clock_flag};
         end else begin
            s_axi_rresp <= 2'h2;
         end
      end
   end

   // ************************************************************
   // oscillator tick and clock-loss supervision
   // ************************************************************
   // oscillator rate enable, stopped in halt
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_div  <= 4'h0;
         osc_tick <= 1'b0;
      end else if (lp_state == ST_HALT) begin
         osc_div  <= 4'h0;
         osc_tick <= 1'b0;
      end else if (osc_div == `CFW_OSC_DIV - 4'h1) begin
         osc_div  <= 4'h0;
         osc_tick <= 1'b1;
      end else begin
         osc_div  <= osc_div + 4'h1;
         osc_tick <= 1'b0;
      end
   end

   wire lost_now = clk_seen && !osc_ok_f && !ctrl[`CFW_CTRL_PLL_OFF] &&
                   (lp_state != ST_HALT);

   // limp fallback armed only after the clock was seen once
   always @(posedge aclk) begin
      if (!aresetn) begin
         clk_seen       <= 1'b0;
         clk_lost       <= 1'b0;
         limp_clock_sel <= 1'b0;
      end else begin
         if (osc_ok_f) begin
            clk_seen <= 1'b1;
         end
         clk_lost       <= lost_now;
         limp_clock_sel <= lost_now;
      end
   end

   // sticky missing-clock flag, set wins over write-one clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         missing_clock_flag <= 1'b0;
      end else if (lost_now && !clk_lost) begin
         missing_clock_flag <= 1'b1;
      end else if (wr_st && wr_strb[0] && wr_data[`CFW_ST_MCLK]) begin
         missing_clock_flag <= 1'b0;
      end
   end

   // device reset pulse on clock loss or watchdog expiry
   always @(posedge aclk) begin
      if (!aresetn) begin
         dev_rst_cnt    <= 5'h00;
         device_reset_n <= 1'b1;
      end else if ((lost_now && !clk_lost) || !wdog_reset_out_n) begin
         dev_rst_cnt    <= `CFW_DEVRST_CYC;
         device_reset_n <= 1'b0;
      end else if (dev_rst_cnt != 5'h00) begin
         dev_rst_cnt    <= dev_rst_cnt - 5'h01;
         device_reset_n <= (dev_rst_cnt == 5'h01);
      end
   end

   // ************************************************************
   // watchdog
   // ************************************************************
   wire wd_run = !ctrl[`CFW_CTRL_WD_DIS] && !limp_clock_sel && osc_tick;
   wire key_ok = wr_key && key_armed &&
                 (wr_data[7:0] == `CFW_KEY_SECOND);

   // key sequence tracker
   always @(posedge aclk) begin
      if (!aresetn) begin
         key_armed <= 1'b0;
      end else if (wr_key) begin
         key_armed <= (wr_data[7:0] == `CFW_KEY_FIRST);
      end
   end

   // up counter, frozen in limp mode, held at zero when disabled
   always @(posedge aclk) begin
      if (!aresetn) begin
         wd_count   <= 8'h00;
         wd_irq_evt <= 1'b0;
      end else begin
         wd_irq_evt <= 1'b0;
         if (key_ok || ctrl[`CFW_CTRL_WD_DIS]) begin
            wd_count <= 8'h00;
         end else if (wd_run) begin
            if (wd_count == `CFW_WD_MAX) begin
               wd_count   <= 8'h00;
               wd_irq_evt <= ctrl[`CFW_CTRL_WD_IRQ];
            end else begin
               wd_count <= wd_count + 8'h01;
            end
         end
      end
   end

   // reset pulse 512 oscillator ticks wide
   always @(posedge aclk) begin
      if (!aresetn) begin
         wd_rst_cnt       <= 10'h000;
         wdog_reset_out_n <= 1'b1;
      end else if (wd_run && (wd_count == `CFW_WD_MAX) && !key_ok &&
                   ~|wd_rst_cnt && !ctrl[`CFW_CTRL_WD_IRQ]) begin
         wd_rst_cnt       <= `CFW_WD_RST_OSC;
         wdog_reset_out_n <= 1'b0;
      end else if (wd_rst_cnt != 10'h000) begin
         if (osc_tick) begin
            wd_rst_cnt       <= wd_rst_cnt - 10'h001;
            wdog_reset_out_n <= (wd_rst_cnt == 10'h001);
         end
      end else begin
         wdog_reset_out_n <= 1'b1;
      end
   end

   // irq pulse to the cpu expander and the low-power block
   always @(posedge aclk) begin
      if (!aresetn) begin
         wdog_wake_irq <= 1'b0;
      end else begin
         wdog_wake_irq <= wd_irq_evt;
      end
   end

   // ************************************************************
   // low-power sequencer
   // ************************************************************
   wire [31:0] wake_lines = ~gpio_f & gpio_wake_select;
   wire        gpio_any   = |wake_lines;
   wire        gpio_qual  = gpio_any && (qual_cnt >= qual_limit);

   // gpio low level must hold steady for the programmed tick count
   always @(posedge aclk) begin
      if (!aresetn) begin
         qual_cnt  <= 6'h00;
         wake_prev <= 32'h0000_0000;
      end else begin
         wake_prev <= wake_lines;
         if (!gpio_any || (wake_lines != wake_prev) ||
             (lp_state != ST_STANDBY)) begin
            qual_cnt <= 6'h00;
         end else if (osc_tick && (qual_cnt != 6'h3F)) begin
            qual_cnt <= qual_cnt + 6'h01;
         end
      end
   end

   reg [1:0] next_lp_state;

   // wake decisions per mode
   always @* begin
      next_lp_state = lp_state;
      case (lp_state)
         ST_RUN: begin
            if (cpu_idle_exec) begin
               if (lowpower_mode_sel == `CFW_LPM_IDLE) begin
                  next_lp_state = ST_IDLE;
               end else if (lowpower_mode_sel == `CFW_LPM_STANDBY) begin
                  next_lp_state = ST_STANDBY;
               end else begin
                  next_lp_state = ST_HALT;
               end
            end
         end
         ST_IDLE: begin
            if (!xrst_n_f || wd_irq_evt || cpu_irq_pending ||
                !nmi_n_f) begin
               next_lp_state = ST_RUN;
            end
         end
         ST_STANDBY: begin
            if (!xrst_n_f || wd_irq_evt || !nmi_n_f || dbg_f ||
                gpio_qual) begin
               next_lp_state = ST_RUN;
            end
         end
         default: begin
            if (!xrst_n_f || gpio_any || !nmi_n_f ||
                dbg_f) begin
               next_lp_state = ST_RUN;
            end
         end
      endcase
   end

   // state and clock-enable outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         lp_state            <= ST_RUN;
         lp_wake             <= 1'b0;
         cpu_clock_in_en     <= 1'b1;
         system_clock_out_en <= 1'b1;
         osc_clock_en        <= 1'b1;
         pin_hold            <= 1'b0;
         jtag_alive          <= 1'b0;
      end else begin
         lp_state <= next_lp_state;
         lp_wake  <= (lp_state != ST_RUN) && (next_lp_state == ST_RUN);
         cpu_clock_in_en     <= (next_lp_state == ST_RUN) ||
                                (next_lp_state == ST_IDLE);
         system_clock_out_en <= (next_lp_state == ST_RUN) ||
                                (next_lp_state == ST_IDLE);
         osc_clock_en        <= (next_lp_state != ST_HALT);
         pin_hold            <= (next_lp_state != ST_RUN);
         jtag_alive          <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// File: logic/cfw_defines.vh
// constants for the clock-fail, watchdog and low-power supervisor
// assumes aclk at 200 MHz and an oscillator reference of 20 MHz
`ifndef CFW_DEFINES_VH
`define CFW_DEFINES_VH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define CFW_OFS_CTRL      12'h000
`define CFW_OFS_LPCTRL0   12'h004
`define CFW_OFS_WAKESEL   12'h008
`define CFW_OFS_WDKEY     12'h00C
`define CFW_OFS_STATUS    12'h010

// ***************************************************************
// field positions
// ***************************************************************
`define CFW_CTRL_WD_DIS   0
`define CFW_CTRL_WD_IRQ   1
`define CFW_CTRL_PLL_OFF  2
`define CFW_ST_MCLK       0
`define CFW_ST_LIMP       1

// ***************************************************************
// reset values and encodings
// ***************************************************************
`define CFW_CTRL_RST      3'h0
`define CFW_LPCTRL0_RST   8'h00
`define CFW_WAKESEL_RST   32'h0000_0000
`define CFW_KEY_FIRST     8'h55
`define CFW_KEY_SECOND    8'hAA
`define CFW_WD_MAX        8'hFF
`define CFW_LPM_IDLE      2'h0
`define CFW_LPM_STANDBY   2'h1

// ***************************************************************
// timing
// ***************************************************************
`define CFW_CLK_PERIOD_NS 5
`define CFW_OSC_PERIOD_NS 50
`define CFW_OSC_DIV       4'hA
`define CFW_WD_RST_OSC    10'h200
`define CFW_DEVRST_CYC    5'h10

`endif

// File: test/cfw_cpu_model.sv
// cpu core model: idle instruction pulse and held interrupt
// assumes bench requests on aclk
`timescale 1ns/1ps
`default_nettype none
// ***************
// cpu core model
// ***************
module cfw_cpu_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic idle_go,
   input  wire logic irq_go,
   input  wire logic lp_wake,
   output var  logic cpu_idle_exec,
   output var  logic cpu_irq_pending
);
   // quiet outputs before the first edge
   initial begin
      cpu_idle_exec = 1'b0;
      cpu_irq_pending = 1'b0;
   end
   // one pulse per idle, interrupt held until woken
   always @(posedge aclk) begin
      if (!aresetn) begin
         cpu_idle_exec <= 1'b0;
         cpu_irq_pending <= 1'b0;
      end else begin
         cpu_idle_exec <= idle_go;
         if (lp_wake)
            cpu_irq_pending <= 1'b0;
         else if (irq_go)
            cpu_irq_pending <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: test/cfw_top_properties.sv
// checker on the supervisor's clock and low-power outputs
// assumes one clock aclk, bound into cfw_top
`timescale 1ns/1ps
`default_nettype none
// ***************
// output checker
// ***************
module cfw_chk (
   input wire       aclk,
   input wire       aresetn,
   input wire       cpu_idle_exec,
   input reg        limp_clock_sel,
   input reg        device_reset_n,
   input reg        missing_clock_flag,
   input reg        wdog_reset_out_n,
   input reg        wdog_wake_irq,
   input reg  [1:0] lp_state,
   input reg        cpu_clock_in_en,
   input reg        system_clock_out_en,
   input reg        osc_clock_en,
   input reg        lp_wake,
   input reg        pin_hold,
   input reg        jtag_alive
);
   int lo;
   // length of the current watchdog reset pulse
   always @(posedge aclk) begin
      if (!aresetn || wdog_reset_out_n)
         lo <= 0;
      else
         lo <= lo + 1;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wd_len; $rose(wdog_reset_out_n) |-> lo >= 5110 && lo <= 5130;
   endproperty
   a_wd_len: assert property (p_wd_len) else $error("wdog pulse width");
   property p_loss; $rose(limp_clock_sel) |->
      ##[0:3] (!device_reset_n && missing_clock_flag); endproperty
   a_loss: assert property (p_loss) else $error("clock loss reaction");
   property p_idle; lp_state == 2'h1 |->
      cpu_clock_in_en && system_clock_out_en && osc_clock_en; endproperty
   a_idle: assert property (p_idle) else $error("idle clocks");
   property p_stby; lp_state == 2'h2 |->
      osc_clock_en && !cpu_clock_in_en && !system_clock_out_en; endproperty
   a_stby: assert property (p_stby) else $error("standby clocks");
   property p_halt; lp_state == 2'h3 |-> !osc_clock_en && !cpu_clock_in_en;
   endproperty
   a_halt: assert property (p_halt) else $error("halt clocks");
   property p_hold; lp_state != 2'h0 |-> pin_hold; endproperty
   a_hold: assert property (p_hold) else $error("pins not held");
   property p_jtag; $past(aresetn) |-> jtag_alive; endproperty
   a_jtag: assert property (p_jtag) else $error("debug port down");
   property p_entry; lp_state != 2'h0 && $past(lp_state) == 2'h0 |->
      $past(cpu_idle_exec); endproperty
   a_entry: assert property (p_entry) else $error("entry w/o idle");
   property p_hwd; lp_state == 2'h3 && $past(lp_state) == 2'h3 |->
      !wdog_wake_irq; endproperty
   a_hwd: assert property (p_hwd) else $error("wdog active in halt");
   property p_wake; lp_wake |-> lp_state == 2'h0 ##1 !lp_wake; endproperty
   a_wake: assert property (p_wake) else $error("wake pulse");
   c_wake: cover property (lp_wake);
   c_wdr: cover property ($rose(wdog_reset_out_n));
   c_limp: cover property ($rose(limp_clock_sel));
endmodule
bind cfw_top cfw_chk chk_u (.aclk, .aresetn, .cpu_idle_exec,
   .limp_clock_sel, .device_reset_n, .missing_clock_flag,
   .wdog_reset_out_n, .wdog_wake_irq, .lp_state, .cpu_clock_in_en,
   .system_clock_out_en, .osc_clock_en, .lp_wake, .pin_hold, .jtag_alive);
`default_nettype wire

// File: test/cfw_top_tb_top.sv
// bench for the clock-fail, watchdog and low-power supervisor
// assumes cfw_top, its defines header and the cpu model
`include "cfw_defines.vh"
`timescale 1ns/1ps
`default_nettype none
// ***************
// bench top
// ***************
module cfw_top_tb_top;
   typedef struct packed {
      logic [7:0] lpc;
      logic [2:0] src;
      logic [3:0] exp;
   } cfw_row_t;
   // wake sources: 0 irq 1 nmi 2 dbg 3 gpio0 4 ext reset
   cfw_row_t rows [9] = '{'{8'h00, 3'd0, 4'h7}, '{8'h00, 3'd1, 4'h7},
      '{8'h00, 3'd4, 4'h7}, '{8'h11, 3'd1, 4'h9}, '{8'h11, 3'd2, 4'h9},
      '{8'h11, 3'd3, 4'h9}, '{8'h02, 3'd3, 4'hC}, '{8'h03, 3'd2, 4'hC},
      '{8'h02, 3'd4, 4'hC}};
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, osc_clock_ok = 1'b1, ext_reset_n = 1'b1;
   logic ext_nmi_n = 1'b1, dbg_wake_req = 1'b0, idle_go = 1'b0;
   logic irq_go = 1'b0, cpu_idle_exec, cpu_irq_pending;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, gpio_in = 32'hFFFF_FFFF;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, lp_state, r;
   logic [31:0] s_axi_rdata, d;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, limp_clock_sel, device_reset_n, missing_clock_flag;
   logic wdog_reset_out_n, wdog_wake_irq, cpu_clock_in_en, lp_wake;
   logic system_clock_out_en, osc_clock_en, pin_hold, jtag_alive;
   int num_errors = 0, compares = 0, wr_n = 0, irq_n = 0, n0, k;
   logic [7:0] c;
   cfw_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_clock_ok,
      .ext_reset_n, .ext_nmi_n, .dbg_wake_req, .gpio_in, .cpu_idle_exec,
      .cpu_irq_pending, .limp_clock_sel, .device_reset_n,
      .missing_clock_flag, .wdog_reset_out_n, .wdog_wake_irq, .lp_state,
      .cpu_clock_in_en, .system_clock_out_en, .osc_clock_en, .lp_wake,
      .pin_hold, .jtag_alive);
   cfw_cpu_model cpu_u (.aclk, .aresetn, .idle_go, .irq_go, .lp_wake,
      .cpu_idle_exec, .cpu_irq_pending);
   // clock, 5 ns period
   initial begin
      forever #2.5 aclk = ~aclk;
   end
   // tally of watchdog reset cycles and irq pulses
   always @(posedge aclk) begin
      if (wdog_reset_out_n === 1'b0)
         wr_n++;
      if (wdog_wake_irq === 1'b1)
         irq_n++;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp, string m);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t %s got %h want %h", $time, m, seen, exp);
      end
   endtask
   task wrap_up;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task tick(int n);
      repeat (n) @(posedge aclk);
   endtask
   task axw(input logic [11:0] a, input logic [31:0] v);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1 && ++n < 200);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1 && ++n < 200);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task rd(input logic [11:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1 && ++n < 200);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1 && ++n < 200);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // drive one wake source active or inactive
   task wk(input logic [2:0] s, input logic on);
      case (s)
         3'd0: irq_go <= on;
         3'd1: ext_nmi_n <= !on;
         3'd2: dbg_wake_req <= on;
         3'd3: gpio_in[0] <= !on;
         3'd4: ext_reset_n <= !on;
         3'd5: gpio_in[1] <= !on;
         default: ;
      endcase
   endtask
   task lp(input logic [7:0] v);
      axw(`CFW_OFS_LPCTRL0, {24'h0, v});
      idle_go <= 1'b1;
      @(posedge aclk);
      idle_go <= 1'b0;
      tick(3);
   endtask
   task wake(input logic [2:0] s, input int lim);
      wk(s, 1'b1);
      k = 0;
      while (lp_wake !== 1'b1 && k < lim) begin
         @(posedge aclk);
         k++;
      end
      wk(s, 1'b0);
      chk(lp_wake, 1, "no wake");
      chk(lp_state, 0, "not running");
      tick(10);
   endtask
   // hang guard, about 60000 cycles
   initial begin
      #300000;
      num_errors++;
      wrap_up;
   end
   initial begin
      tick(16);
      aresetn <= 1'b1;
      @(posedge aclk);
      axw(`CFW_OFS_WAKESEL, 32'h1);
      foreach (rows[i]) begin
         lp(rows[i].lpc);
         chk({lp_state, cpu_clock_in_en, osc_clock_en},
            rows[i].exp, "modes");
         chk(pin_hold, 1, "pins free");
         wake(rows[i].src, 300);
         if (rows[i].src == 3'd3 && rows[i].lpc == 8'h11)
            chk(k >= 35, 1, "gpio unqualified");
      end
      $display("mode table done");
      axw(12'h020, 32'h0);
      chk(r, 2'h2, "unmapped write");
      rd(`CFW_OFS_STATUS);
      chk(d[3:0], 4'h0, "status reset");
      chk(jtag_alive, 1, "debug port");
      n0 = wr_n;
      repeat (12) begin
         tick(1000);
         axw(`CFW_OFS_WDKEY, `CFW_KEY_FIRST);
         axw(`CFW_OFS_WDKEY, `CFW_KEY_SECOND);
      end
      chk(wr_n, n0, "serviced wdog fired");
      tick(500);
      axw(`CFW_OFS_WDKEY, `CFW_KEY_FIRST);
      axw(`CFW_OFS_WDKEY, 32'h11);
      axw(`CFW_OFS_WDKEY, `CFW_KEY_SECOND);
      rd(`CFW_OFS_STATUS);
      chk(d[15:8] >= 8'h28, 1, "broken key cleared");
      $display("key test done");
      k = 0;
      while (wdog_reset_out_n !== 1'b0 && k < 3000) begin
         @(posedge aclk);
         k++;
      end
      tick(5200);
      chk(wr_n - n0 >= 5110 && wr_n - n0 <= 5130, 1, "wdog width");
      axw(`CFW_OFS_CTRL, 32'h1);
      n0 = wr_n;
      tick(3000);
      chk(wr_n, n0, "disabled wdog fired");
      lp(8'h11);
      wk(3'd5, 1'b1);
      tick(300);
      chk(lp_state, 2'h2, "unselected line woke");
      wk(3'd5, 1'b0);
      wake(3'd1, 300);
      axw(`CFW_OFS_CTRL, 32'h2);
      lp(8'h02);
      n0 = irq_n;
      tick(3000);
      chk(lp_state, 2'h3, "halt left");
      chk(irq_n, n0, "wdog ran in halt");
      wake(3'd1, 300);
      lp(8'h00);
      wake(3'd6, 3000);
      lp(8'h01);
      wake(3'd6, 3000);
      $display("low-power test done");
      axw(`CFW_OFS_CTRL, 32'h0);
      osc_clock_ok <= 1'b0;
      tick(40);
      chk(limp_clock_sel, 1, "no limp");
      chk(missing_clock_flag, 1, "no flag");
      rd(`CFW_OFS_STATUS);
      c = d[15:8];
      chk(d[1:0], 2'h3, "status loss");
      tick(300);
      rd(`CFW_OFS_STATUS);
      chk(d[15:8], c, "wdog ran in limp");
      $display("clock loss test done");
      wrap_up;
   end
endmodule
`default_nettype wire
